// [src/hwt_params.svh]
// Offsets, reset values and derivation constants of the haptic tuning bank
`ifndef HWT_PARAMS_SVH
`define HWT_PARAMS_SVH

`define HWT_ADDR_NEG_SUSTAIN 8'h1C
`define HWT_ADDR_BRAKE_TIME 8'h1D
`define HWT_ADDR_FULL_SCALE 8'h1F
`define HWT_ADDR_OD_LIMIT 8'h20
`define HWT_ADDR_LOSS_COMP 8'h21
`define HWT_ADDR_FB_LEVEL 8'h22

`define HWT_RST_NEG_SUSTAIN 8'h00
`define HWT_RST_BRAKE_TIME 8'h00
`define HWT_RST_FULL_SCALE 8'h3F
`define HWT_RST_OD_LIMIT 8'hFF
`define HWT_RST_LOSS_COMP 8'h0D
`define HWT_RST_FB_LEVEL 8'h6D

`define HWT_LEVEL_START_MIN 8'h7F
`define HWT_LEVEL_START_MAX 8'h80
`define HWT_LOSS_COMP_SHIFT 2
`define HWT_SCALE_SHIFT 8
`define HWT_READ_UNMAPPED 8'h00

`endif

// [src/hwt_pkg.sv]
// Types shared by the haptic waveform tuning bank
package hwt_pkg;

  typedef logic [7:0] hwt_byte_t;
  typedef logic signed [7:0] hwt_level_t;
  typedef logic [8:0] hwt_steps_t;
  typedef logic signed [16:0] hwt_delta_ms_t;

  typedef enum logic [2:0]
  {
    SEG_NONE,
    SEG_OVERDRIVE,
    SEG_POS_SUSTAIN,
    SEG_NEG_SUSTAIN,
    SEG_BRAKE
  } hwt_seg_class_t;

  typedef enum logic [1:0]
  {
    ST_IDLE,
    ST_SCAN,
    ST_PLAY
  } hwt_state_t;

endpackage

// [src/hwt_seg_if.sv]
// Carrier between the bank and its segment adjuster
`timescale 1ns/1ns
interface hwt_seg_if;
  import hwt_pkg::*;
  hwt_level_t level;
  hwt_level_t wave_max;
  hwt_level_t wave_min;
  logic [7:0] base_steps;
  logic [7:0] step_period;
  logic closed_loop;
  hwt_byte_t neg_sustain_offset;
  hwt_byte_t brake_time_offset;
  hwt_seg_class_t seg_class;
  hwt_steps_t adj_steps;
  hwt_delta_ms_t delta_ms;

  modport bank
  (
    output level, wave_max, wave_min, base_steps, step_period, closed_loop,
    output neg_sustain_offset, brake_time_offset,
    input seg_class, adj_steps, delta_ms
  );
  modport adjuster
  (
    input level, wave_max, wave_min, base_steps, step_period, closed_loop,
    input neg_sustain_offset, brake_time_offset,
    output seg_class, adj_steps, delta_ms
  );
endinterface

// [src/hwt_seg_adjust.sv]
// Classifies one waveform sample and lengthens or shortens its duration by the signed offsets
`timescale 1ns/1ns
module hwt_seg_adjust
(
  hwt_seg_if.adjuster seg
);
  import hwt_pkg::*;

  logic signed [7:0] offset;
  logic signed [9:0] sum;

  always_comb
  begin
    offset = 8'sh00;
    if (seg.level == seg.wave_max && seg.level > 8'sh00)
    begin
      seg.seg_class = SEG_OVERDRIVE;
    end
    else if (seg.level > 8'sh00)
    begin
      seg.seg_class = SEG_POS_SUSTAIN;
    end
    else if (seg.level < 8'sh00 && seg.level == seg.wave_min)
    begin
      seg.seg_class = SEG_BRAKE; // [RL5]
      // Closed loop brakes on its own, so the offset is dropped there
      if (!seg.closed_loop)
      begin
        offset = $signed(seg.brake_time_offset); // [RL4] [RL6]
      end
    end
    else if (seg.level < 8'sh00)
    begin
      seg.seg_class = SEG_NEG_SUSTAIN; // [RL2]
      offset = $signed(seg.neg_sustain_offset); // [RL1]
    end
    else
    begin
      seg.seg_class = SEG_NONE;
    end
    sum = $signed({2'b00, seg.base_steps}) + 10'(offset);
    // A segment can shrink to nothing but never below
    if (sum < 10'sh000)
    begin
      seg.adj_steps = 9'h000;
    end
    else
    begin
      seg.adj_steps = sum[8:0];
    end
    seg.delta_ms = 17'(offset) * $signed({9'h000, seg.step_period}); // [RL3] [RL7]
  end

endmodule // hwt_seg_adjust

// [src/hwt_tuning_regs.sv]
// Haptic waveform tuning register bank with segment timing and drive limiting
// What this block does; RL9 and RL10 are duties of software
// RL1: Negative sustain lengthened by its offset register
// RL2: Non-braking negative samples count as sustain
// RL3: Sustain offset signed, times step period
// RL4: Braking segment lengthened by brake offset
// RL5: Braking is the most negative level
// RL6: Brake offset applies in open loop only
// RL7: Brake offset signed, times step period
// RL8: Full-scale level sets closed-loop full scale
// RL9: Software writes rated level before calibration
// RL10: Software recalibrates after changing full scale
// RL11: Closed-loop overdrive and braking clamped to limit
// RL12: Calibration stores loss compensation, offsets losses
// RL13: Loss compensation derived from measured impedance
// RL14: Feedback gain derived from feedback level
// RL15: Eight-bit registers, read back, reset defaults
`timescale 1ns/1ns
`include "hwt_params.svh"
module hwt_tuning_regs
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_rvalid_o,
  input wire logic closed_loop_i,
  input wire logic [7:0] step_period_i,
  input wire logic wave_start_i,
  input wire logic scan_valid_i,
  input wire hwt_pkg::hwt_level_t scan_level_i,
  input wire logic play_valid_i,
  input wire hwt_pkg::hwt_level_t play_level_i,
  input wire logic [7:0] play_steps_i,
  output hwt_pkg::hwt_seg_class_t seg_class_o,
  output hwt_pkg::hwt_steps_t seg_steps_o,
  output hwt_pkg::hwt_delta_ms_t seg_delta_ms_o,
  output logic seg_valid_o,
  input wire logic drive_valid_i,
  input wire logic [7:0] drive_req_i,
  input wire logic od_brake_phase_i,
  input wire logic [7:0] fb_demand_i,
  output logic [7:0] drive_level_o,
  output logic drive_valid_o,
  input wire logic cal_done_i,
  input wire logic [7:0] cal_impedance_i,
  input wire logic [7:0] cal_feedback_i,
  output logic [7:0] fb_gain_o,
  output logic [1:0] phase_o
);
  import hwt_pkg::*;

  hwt_seg_if seg ();

  hwt_byte_t neg_sustain_offset_reg, neg_sustain_offset_next;
  hwt_byte_t brake_time_offset_reg, brake_time_offset_next;
  hwt_byte_t full_scale_drive_level_reg, full_scale_drive_level_next;
  hwt_byte_t overdrive_voltage_limit_reg, overdrive_voltage_limit_next;
  hwt_byte_t calibrated_loss_compensation_reg, calibrated_loss_compensation_next;
  hwt_byte_t calibrated_feedback_level_reg, calibrated_feedback_level_next;
  logic [7:0] reg_rdata_reg, reg_rdata_next;
  logic reg_rvalid_reg, reg_rvalid_next;

  hwt_state_t state_reg, state_next;
  hwt_level_t wave_min_reg, wave_min_next;
  hwt_level_t wave_max_reg, wave_max_next;

  hwt_seg_class_t seg_class_reg, seg_class_next;
  hwt_steps_t seg_steps_reg, seg_steps_next;
  hwt_delta_ms_t seg_delta_ms_reg, seg_delta_ms_next;
  logic seg_valid_reg, seg_valid_next;

  logic [7:0] drive_level_reg, drive_level_next;
  logic drive_valid_reg, drive_valid_next;
  logic [7:0] fb_gain_reg, fb_gain_next;

  logic [15:0] scaled;
  logic [7:0] target;
  logic [15:0] loss_term;
  logic [8:0] compensated;
  logic [7:0] comp_sat;
  logic [7:0] derived_comp;

  // Register access: writes land next edge, reads answer one cycle later
  always_comb
  begin
    neg_sustain_offset_next = neg_sustain_offset_reg;
    brake_time_offset_next = brake_time_offset_reg;
    full_scale_drive_level_next = full_scale_drive_level_reg;
    overdrive_voltage_limit_next = overdrive_voltage_limit_reg;
    calibrated_loss_compensation_next = calibrated_loss_compensation_reg;
    calibrated_feedback_level_next = calibrated_feedback_level_reg;
    derived_comp = cal_impedance_i >> `HWT_LOSS_COMP_SHIFT;
    if (reg_wr_i)
    begin
      case (reg_addr_i)
        `HWT_ADDR_NEG_SUSTAIN: neg_sustain_offset_next = reg_wdata_i; // [RL15]
        `HWT_ADDR_BRAKE_TIME: brake_time_offset_next = reg_wdata_i; // [RL15]
        `HWT_ADDR_FULL_SCALE: full_scale_drive_level_next = reg_wdata_i; // [RL15]
        `HWT_ADDR_OD_LIMIT: overdrive_voltage_limit_next = reg_wdata_i; // [RL15]
        `HWT_ADDR_LOSS_COMP: calibrated_loss_compensation_next = reg_wdata_i; // [RL15]
        `HWT_ADDR_FB_LEVEL: calibrated_feedback_level_next = reg_wdata_i; // [RL15]
        default:
        begin
        end
      endcase
    end
    // A finishing calibration wins over a host write in the same cycle
    if (cal_done_i)
    begin
      calibrated_loss_compensation_next = derived_comp; // [RL12] [RL13]
      calibrated_feedback_level_next = cal_feedback_i;
    end
    reg_rvalid_next = reg_rd_i;
    reg_rdata_next = reg_rdata_reg;
    if (reg_rd_i)
    begin
      case (reg_addr_i)
        `HWT_ADDR_NEG_SUSTAIN: reg_rdata_next = neg_sustain_offset_reg;
        `HWT_ADDR_BRAKE_TIME: reg_rdata_next = brake_time_offset_reg;
        `HWT_ADDR_FULL_SCALE: reg_rdata_next = full_scale_drive_level_reg;
        `HWT_ADDR_OD_LIMIT: reg_rdata_next = overdrive_voltage_limit_reg;
        `HWT_ADDR_LOSS_COMP: reg_rdata_next = calibrated_loss_compensation_reg;
        `HWT_ADDR_FB_LEVEL: reg_rdata_next = calibrated_feedback_level_reg;
        default: reg_rdata_next = `HWT_READ_UNMAPPED;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      neg_sustain_offset_reg <= `HWT_RST_NEG_SUSTAIN; // [RL15]
      brake_time_offset_reg <= `HWT_RST_BRAKE_TIME;
      full_scale_drive_level_reg <= `HWT_RST_FULL_SCALE;
      overdrive_voltage_limit_reg <= `HWT_RST_OD_LIMIT;
      calibrated_loss_compensation_reg <= `HWT_RST_LOSS_COMP;
      calibrated_feedback_level_reg <= `HWT_RST_FB_LEVEL;
      reg_rdata_reg <= 8'h00;
      reg_rvalid_reg <= 1'b0;
    end
    else
    begin
      neg_sustain_offset_reg <= neg_sustain_offset_next;
      brake_time_offset_reg <= brake_time_offset_next;
      full_scale_drive_level_reg <= full_scale_drive_level_next;
      overdrive_voltage_limit_reg <= overdrive_voltage_limit_next;
      calibrated_loss_compensation_reg <= calibrated_loss_compensation_next;
      calibrated_feedback_level_reg <= calibrated_feedback_level_next;
      reg_rdata_reg <= reg_rdata_next;
      reg_rvalid_reg <= reg_rvalid_next;
    end
  end

  // Waveform scan finds its extremes before any sample plays; the
  // engine must scan the whole waveform first or the brake is misjudged
  always_comb
  begin
    state_next = state_reg;
    wave_min_next = wave_min_reg;
    wave_max_next = wave_max_reg;
    case (state_reg)
      ST_IDLE:
      begin
        if (wave_start_i)
        begin
          state_next = ST_SCAN;
          wave_min_next = `HWT_LEVEL_START_MIN;
          wave_max_next = `HWT_LEVEL_START_MAX;
        end
      end
      ST_SCAN:
      begin
        if (scan_valid_i)
        begin
          if (scan_level_i < wave_min_reg)
          begin
            wave_min_next = scan_level_i; // [RL5]
          end
          if (scan_level_i > wave_max_reg)
          begin
            wave_max_next = scan_level_i;
          end
        end
        if (play_valid_i)
        begin
          state_next = ST_PLAY;
        end
      end
      ST_PLAY:
      begin
        if (wave_start_i)
        begin
          state_next = ST_SCAN;
          wave_min_next = `HWT_LEVEL_START_MIN;
          wave_max_next = `HWT_LEVEL_START_MAX;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      state_reg <= ST_IDLE;
      wave_min_reg <= `HWT_LEVEL_START_MIN;
      wave_max_reg <= `HWT_LEVEL_START_MAX;
    end
    else
    begin
      state_reg <= state_next;
      wave_min_reg <= wave_min_next;
      wave_max_reg <= wave_max_next;
    end
  end

  assign seg.level = play_level_i;
  assign seg.wave_max = wave_max_reg;
  assign seg.wave_min = wave_min_reg;
  assign seg.base_steps = play_steps_i;
  assign seg.step_period = step_period_i;
  assign seg.closed_loop = closed_loop_i;
  assign seg.neg_sustain_offset = neg_sustain_offset_reg;
  assign seg.brake_time_offset = brake_time_offset_reg;

  hwt_seg_adjust u_adjust
  (
    .seg(seg.adjuster)
  );

  always_comb
  begin
    seg_class_next = seg_class_reg;
    seg_steps_next = seg_steps_reg;
    seg_delta_ms_next = seg_delta_ms_reg;
    seg_valid_next = 1'b0;
    if (play_valid_i && state_reg != ST_IDLE)
    begin
      seg_class_next = seg.seg_class;
      seg_steps_next = seg.adj_steps; // [RL1] [RL4]
      seg_delta_ms_next = seg.delta_ms; // [RL3] [RL7]
      seg_valid_next = 1'b1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      seg_class_reg <= SEG_NONE;
      seg_steps_reg <= 9'h000;
      seg_delta_ms_reg <= 17'sh00000;
      seg_valid_reg <= 1'b0;
    end
    else
    begin
      seg_class_reg <= seg_class_next;
      seg_steps_reg <= seg_steps_next;
      seg_delta_ms_reg <= seg_delta_ms_next;
      seg_valid_reg <= seg_valid_next;
    end
  end

  // Drive path: scale to full scale, add loss compensation, clamp
  always_comb
  begin
    scaled = drive_req_i * full_scale_drive_level_reg; // [RL8]
    target = scaled[15:8];
    loss_term = target * calibrated_loss_compensation_reg;
    compensated = {1'b0, target} + {1'b0, loss_term[15:8]}; // [RL12]
    comp_sat = compensated[8] ? 8'hFF : compensated[7:0];
    drive_level_next = drive_level_reg;
    drive_valid_next = drive_valid_i;
    if (drive_valid_i)
    begin
      if (closed_loop_i && od_brake_phase_i)
      begin
        // Feedback may push past full scale here, but only to the limit
        if (fb_demand_i > overdrive_voltage_limit_reg)
        begin
          drive_level_next = overdrive_voltage_limit_reg; // [RL11]
        end
        else
        begin
          drive_level_next = fb_demand_i; // [RL11]
        end
      end
      else
      begin
        drive_level_next = comp_sat;
      end
    end
    fb_gain_next = calibrated_feedback_level_reg; // [RL14]
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      drive_level_reg <= 8'h00;
      drive_valid_reg <= 1'b0;
      fb_gain_reg <= `HWT_RST_FB_LEVEL;
    end
    else
    begin
      drive_level_reg <= drive_level_next;
      drive_valid_reg <= drive_valid_next;
      fb_gain_reg <= fb_gain_next;
    end
  end

  assign reg_rdata_o = reg_rdata_reg;
  assign reg_rvalid_o = reg_rvalid_reg;
  assign seg_class_o = seg_class_reg;
  assign seg_steps_o = seg_steps_reg;
  assign seg_delta_ms_o = seg_delta_ms_reg;
  assign seg_valid_o = seg_valid_reg;
  assign drive_level_o = drive_level_reg;
  assign drive_valid_o = drive_valid_reg;
  assign fb_gain_o = fb_gain_reg;
  assign phase_o = state_reg;

endmodule // hwt_tuning_regs

// [dv/hwt_tuning_regs_assertions.sv]
// Port-level assertions for the haptic tuning bank
`timescale 1ns/1ns
module hwt_regs_checker
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic reg_rd_i,
  input wire logic reg_rvalid_o,
  input wire logic closed_loop_i,
  input wire logic play_valid_i,
  input wire hwt_pkg::hwt_level_t play_level_i,
  input wire hwt_pkg::hwt_seg_class_t seg_class_o,
  input wire hwt_pkg::hwt_delta_ms_t seg_delta_ms_o,
  input wire logic seg_valid_o,
  input wire logic drive_valid_i,
  input wire logic od_brake_phase_i,
  input wire logic [7:0] fb_demand_i,
  input wire logic [7:0] drive_level_o,
  input wire logic drive_valid_o,
  input wire logic cal_done_i,
  input wire logic [7:0] cal_feedback_i,
  input wire logic [7:0] fb_gain_o,
  input wire logic [1:0] phase_o
);
  import hwt_pkg::*;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  AST_RVALID_AFTER_READ: assert property (reg_rd_i |=> reg_rvalid_o)
    else $error("read valid missing");
  AST_RVALID_ONLY_READ: assert property (!reg_rd_i |=> !reg_rvalid_o)
    else $error("read valid without read");
  AST_SEG_ANSWER: assert property (play_valid_i && phase_o != 2'h0 |=> seg_valid_o)
    else $error("segment answer missing");
  AST_SEG_IDLE_REFUSED: assert property (play_valid_i && phase_o == 2'h0 |=> !seg_valid_o)
    else $error("segment accepted in idle");
  AST_NEG_CLASS: assert property (play_valid_i && phase_o != 2'h0 && play_level_i < 0
    |=> seg_class_o inside {SEG_NEG_SUSTAIN, SEG_BRAKE})
    else $error("negative sample misclassified");
  AST_OTHER_NO_DELTA: assert property (seg_valid_o
    && !(seg_class_o inside {SEG_NEG_SUSTAIN, SEG_BRAKE}) |-> seg_delta_ms_o == 17'sh0)
    else $error("offset applied to wrong class");
  AST_CLOSED_BRAKE_FIXED: assert property (play_valid_i && phase_o != 2'h0
    && closed_loop_i |=> seg_class_o != SEG_BRAKE || seg_delta_ms_o == 17'sh0)
    else $error("brake offset used in closed loop");
  AST_DRIVE_ANSWER: assert property (drive_valid_i |=> drive_valid_o)
    else $error("drive answer missing");
  AST_OD_NOT_ABOVE_DEMAND: assert property (drive_valid_i && closed_loop_i
    && od_brake_phase_i |=> drive_level_o <= $past(fb_demand_i))
    else $error("overdrive level above demand");
  AST_FB_GAIN_FOLLOWS: assert property (cal_done_i
    |-> ##2 fb_gain_o == $past(cal_feedback_i, 2))
    else $error("feedback gain not updated");
endmodule // hwt_regs_checker

bind hwt_tuning_regs hwt_regs_checker i_hwt_regs_checker
(
  .clk_i(clk_i),
  .rst_b_i(rst_b_i),
  .reg_rd_i(reg_rd_i),
  .reg_rvalid_o(reg_rvalid_o),
  .closed_loop_i(closed_loop_i),
  .play_valid_i(play_valid_i),
  .play_level_i(play_level_i),
  .seg_class_o(seg_class_o),
  .seg_delta_ms_o(seg_delta_ms_o),
  .seg_valid_o(seg_valid_o),
  .drive_valid_i(drive_valid_i),
  .od_brake_phase_i(od_brake_phase_i),
  .fb_demand_i(fb_demand_i),
  .drive_level_o(drive_level_o),
  .drive_valid_o(drive_valid_o),
  .cal_done_i(cal_done_i),
  .cal_feedback_i(cal_feedback_i),
  .fb_gain_o(fb_gain_o),
  .phase_o(phase_o)
);

// [dv/hwt_testbench.sv]
// Self-checking bench for the haptic tuning bank
`timescale 1ns/1ns
module testbench;
  import hwt_pkg::*;
  logic clk_i, rst_b_i, reg_wr_i, reg_rd_i, reg_rvalid_o, closed_loop_i, wave_start_i;
  logic scan_valid_i, play_valid_i, seg_valid_o, drive_valid_i, od_brake_phase_i;
  logic drive_valid_o, cal_done_i;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, step_period_i, play_steps_i;
  logic [7:0] drive_req_i, fb_demand_i, drive_level_o, cal_impedance_i, cal_feedback_i;
  logic [7:0] fb_gain_o;
  logic [1:0] phase_o;
  hwt_level_t scan_level_i, play_level_i;
  hwt_seg_class_t seg_class_o;
  hwt_steps_t seg_steps_o;
  hwt_delta_ms_t seg_delta_ms_o;
  int n_errors = 0;
  int checks_done = 0;
  logic [7:0] addrs [6] = '{8'h1C, 8'h1D, 8'h1F, 8'h20, 8'h21, 8'h22};
  logic [7:0] dflt [6] = '{8'h00, 8'h00, 8'h3F, 8'hFF, 8'h0D, 8'h6D};

  hwt_tuning_regs i_hwt_tuning_regs
  (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .reg_rvalid_o(reg_rvalid_o), .closed_loop_i(closed_loop_i),
    .step_period_i(step_period_i), .wave_start_i(wave_start_i),
    .scan_valid_i(scan_valid_i), .scan_level_i(scan_level_i),
    .play_valid_i(play_valid_i), .play_level_i(play_level_i),
    .play_steps_i(play_steps_i), .seg_class_o(seg_class_o), .seg_steps_o(seg_steps_o),
    .seg_delta_ms_o(seg_delta_ms_o), .seg_valid_o(seg_valid_o),
    .drive_valid_i(drive_valid_i), .drive_req_i(drive_req_i),
    .od_brake_phase_i(od_brake_phase_i), .fb_demand_i(fb_demand_i),
    .drive_level_o(drive_level_o), .drive_valid_o(drive_valid_o),
    .cal_done_i(cal_done_i), .cal_impedance_i(cal_impedance_i),
    .cal_feedback_i(cal_feedback_i), .fb_gain_o(fb_gain_o), .phase_o(phase_o)
  );

  always #5 clk_i = ~clk_i;

  task automatic chk(input logic [16:0] got, input logic [16:0] exp, input string what);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    @(negedge clk_i);
    reg_wr_i = 1'b0;
  endtask

  // Read data is judged in the single cycle that its valid pulse stands
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk_i);
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    @(negedge clk_i);
    reg_rd_i = 1'b0;
    chk({8'h00, reg_rvalid_o, reg_rdata_o}, {9'h001, exp}, "register read");
  endtask

  task automatic new_wave(input hwt_level_t a, input hwt_level_t b);
    @(negedge clk_i);
    wave_start_i = 1'b1;
    @(negedge clk_i);
    wave_start_i = 1'b0;
    scan_valid_i = 1'b1;
    scan_level_i = a;
    @(negedge clk_i);
    scan_level_i = b;
    @(negedge clk_i);
    scan_valid_i = 1'b0;
    chk({15'h0, phase_o}, 17'h1, "scan phase");
  endtask

  task automatic play(input hwt_level_t lv, input logic [7:0] st, input hwt_seg_class_t c,
    input logic [8:0] es, input int dl);
    @(negedge clk_i);
    play_valid_i = 1'b1;
    play_level_i = lv;
    play_steps_i = st;
    @(negedge clk_i);
    play_valid_i = 1'b0;
    chk({13'h0, seg_valid_o, seg_class_o}, {14'h1, c}, "segment class");
    chk({8'h00, seg_steps_o}, {8'h00, es}, "segment steps");
    chk(seg_delta_ms_o, dl[16:0], "segment delta");
    chk({15'h0, phase_o}, 17'h2, "play phase");
  endtask

  task automatic drive(input logic [7:0] req, input logic [7:0] exp);
    @(negedge clk_i);
    drive_valid_i = 1'b1;
    drive_req_i = req;
    @(negedge clk_i);
    drive_valid_i = 1'b0;
    chk({8'h00, drive_valid_o, drive_level_o}, {9'h001, exp}, "drive level");
  endtask

  task automatic t_regs();
    chk(fb_gain_o, 8'h6D, "feedback gain at reset");
    foreach (addrs[i]) rd(addrs[i], dflt[i]);
    wr(8'h1E, 8'h5A);
    rd(8'h1E, 8'h00);
    foreach (addrs[i]) wr(addrs[i], 8'hA5 ^ addrs[i]);
    foreach (addrs[i]) rd(addrs[i], 8'hA5 ^ addrs[i]);
    // Mid-run reset must bring every written register back to its default
    @(negedge clk_i);
    rst_b_i = 1'b0;
    repeat (2) @(negedge clk_i);
    rst_b_i = 1'b1;
    foreach (addrs[i]) rd(addrs[i], dflt[i]);
    chk(fb_gain_o, 8'h6D, "feedback gain after reset");
  endtask

  task automatic t_segments();
    // Play before any wave start must be ignored while idle
    @(negedge clk_i);
    play_valid_i = 1'b1;
    @(negedge clk_i);
    play_valid_i = 1'b0;
    chk(seg_valid_o, 1'b0, "idle play refused");
    chk({15'h0, phase_o}, 17'h0, "idle phase");
    step_period_i = 8'd7;
    wr(8'h1C, 8'hFE);
    wr(8'h1D, 8'h03);
    new_wave(-8'sd10, -8'sd40);
    play(-8'sd10, 8'd20, SEG_NEG_SUSTAIN, 9'd18, -14);
    wr(8'h1C, 8'h05);
    play(-8'sd10, 8'd20, SEG_NEG_SUSTAIN, 9'd25, 35);
    play(-8'sd40, 8'd10, SEG_BRAKE, 9'd13, 21);
    wr(8'h1D, 8'hFD);
    play(-8'sd40, 8'd2, SEG_BRAKE, 9'd0, -21);
    closed_loop_i = 1'b1;
    play(-8'sd40, 8'd10, SEG_BRAKE, 9'd10, 0);
    closed_loop_i = 1'b0;
    // Offsets stay nonzero here, so the positive classes must ignore them
    new_wave(8'sd50, -8'sd40);
    play(8'sd50, 8'd10, SEG_OVERDRIVE, 9'd10, 0);
    play(8'sd20, 8'd10, SEG_POS_SUSTAIN, 9'd10, 0);
    play(8'sd0, 8'd10, SEG_NONE, 9'd10, 0);
  endtask

  task automatic t_drive();
    wr(8'h1F, 8'h80);
    wr(8'h21, 8'h40);
    drive(8'hFF, 8'h9E);
    wr(8'h20, 8'h40);
    closed_loop_i = 1'b1;
    od_brake_phase_i = 1'b1;
    fb_demand_i = 8'h80;
    drive(8'hFF, 8'h40);
    fb_demand_i = 8'h30;
    drive(8'hFF, 8'h30);
    od_brake_phase_i = 1'b0;
    drive(8'hFF, 8'h9E);
    closed_loop_i = 1'b0;
  endtask

  task automatic t_cal();
    // Calibration reruns after the full-scale change; a host write collides
    @(negedge clk_i);
    cal_done_i = 1'b1;
    cal_impedance_i = 8'h28;
    cal_feedback_i = 8'h50;
    reg_addr_i = 8'h22;
    reg_wdata_i = 8'h11;
    reg_wr_i = 1'b1;
    @(negedge clk_i);
    cal_done_i = 1'b0;
    reg_wr_i = 1'b0;
    @(negedge clk_i);
    chk(fb_gain_o, 8'h50, "feedback gain");
    rd(8'h21, 8'h0A);
    rd(8'h22, 8'h50);
  endtask

  task automatic report_and_stop();
    $display("Errors %0d, checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    {clk_i, rst_b_i, reg_wr_i, reg_rd_i, closed_loop_i, wave_start_i} = '0;
    {scan_valid_i, play_valid_i, drive_valid_i, od_brake_phase_i, cal_done_i} = '0;
    {reg_addr_i, reg_wdata_i, step_period_i, play_steps_i, drive_req_i} = '0;
    {fb_demand_i, cal_impedance_i, cal_feedback_i, scan_level_i, play_level_i} = '0;
    repeat (2) @(negedge clk_i);
    rst_b_i = 1'b1;
    t_regs();
    t_segments();
    t_drive();
    t_cal();
    report_and_stop();
  end

  // Whole run is about 110 cycles; this margin only catches a hang
  initial
  begin
    #50000;
    n_errors++;
    report_and_stop();
  end
endmodule // testbench
